/* File: dbgc_pkg.sv */
// Package with register map, field positions and state of the debug comparator block
package dbgc_pkg;

   // Register offsets on the byte-wide register port
   localparam logic [7:0] OFS_DEBUG_CONTROL_ONE = 8'h20;
   localparam logic [7:0] OFS_COMPARATOR_A_CONTROL = 8'h21;
   localparam logic [7:0] OFS_COMPARATOR_B_CONTROL = 8'h22;
   localparam logic [7:0] OFS_COMPARATOR_C_CONTROL = 8'h23;
   localparam logic [7:0] OFS_MATCH_STATUS = 8'h24;
   localparam logic [7:0] OFS_COMPARATOR_ADDRESS_LOW = 8'h2b;
   localparam logic [7:0] OFS_COMPARATOR_DATA_HIGH = 8'h2c;
   localparam logic [7:0] OFS_COMPARATOR_DATA_LOW = 8'h2d;
   localparam logic [7:0] OFS_COMPARATOR_DATA_HIGH_MASK = 8'h2e;
   localparam logic [7:0] OFS_COMPARATOR_DATA_LOW_MASK = 8'h2f;

   // Field positions in debug_control_one
   localparam int CTL1_ARM_BIT = 7;
   localparam int CTL1_BANK_LSB = 0;

   // Field positions in the comparator control registers
   localparam int CCTL_TAG_BIT = 5;
   localparam int CCTL_ENABLE_BIT = 0;

   // Register bank selector codes
   localparam logic [1:0] BANK_A = 2'h0;
   localparam logic [1:0] BANK_B = 2'h1;
   localparam logic [1:0] BANK_C = 2'h2;
   localparam logic [1:0] BANK_NONE = 2'h3;

   // Reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [1:0] RST_BANK = 2'h0;
   localparam logic [2:0] RST_MATCH = 3'h0;
   localparam logic [2:0] RST_CMP_EN = 3'h0;

   // Number of comparators
   localparam int NUM_CMP = 3;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] addr_low_a;
      logic [7:0] addr_low_b;
      logic [7:0] addr_low_c;
      logic [7:0] data_high;
      logic [7:0] data_low;
      logic [7:0] mask_high;
      logic [7:0] mask_low;
      logic arm;
      logic [1:0] bank;
      logic tag_a;
      logic [2:0] cmp_en;
      logic [2:0] match;
      logic [2:0] sticky;
      logic [7:0] rdata;
   } dbgc_state_t;

endpackage

/* File: dbgc_bit_match.sv */
// Bitwise compare of a bus value against compare bits, qualified by a participation mask
module dbgc_bit_match #(
   parameter int WIDTH = 8
) (
   // Observed value and settings
   input wire logic [WIDTH-1:0] value,
   input wire logic [WIDTH-1:0] compare,
   input wire logic [WIDTH-1:0] mask,
   // Result
   output logic hit
);

   // Zero expects low, one expects high; mask zero lets any value through
   assign hit = &(~(value ^ compare) | ~mask);

endmodule

/* File: dbgc_comparator_regs.sv */
// Debug bus comparator compare registers, register port and match logic
// How it works
// - Each comparator compares address bits 7..0 with its address low register.
// - Address compare bit zero expects low, one expects high.
// - Address low register readable in banks A, B and C, written only while not armed.
// - Comparator A compares data bits 15..8 against the data high register.
// - Comparator A compares data bits 7..0 against the data low register.
// - A data bit takes part only when its mask bit is one.
// - Only comparator A has data registers; B and C ignore data.
// - Comparator A skips data compare while its tag bit is set.
// - Data and mask registers read only while bank selector is 00.
// - Data and mask writes need bank 00 and module not armed.
// - Data high mask register sits at offset 0x2e, qualifies bits 15..8.
// - Bank selector picks A, B, C or none for the address window.
// - Mask zero lets any data value match, mask one compares it.
// - Setting the arm bit arms the module and enables match reporting.
//
// Our own choice: the plain strobed port.
module dbgc_comparator_regs (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Observed core bus
   input wire logic bus_valid,
   input wire logic [7:0] bus_addr,
   input wire logic [15:0] bus_data,
   // Match results
   output logic [2:0] match,
   output logic armed
);

   dbgc_pkg::dbgc_state_t st_r;
   dbgc_pkg::dbgc_state_t st_nxt;

   logic [7:0] addr_low_sel;
   logic bank_is_a;
   logic wr_addr_low;
   logic wr_data_ok;
   logic [2:0] addr_hit;
   logic data_hit_hi;
   logic data_hit_lo;
   logic data_hit;
   logic [2:0] raw_match;
   logic [7:0] rd_val;
   logic bank_visible;
   logic rd_data_ok;
   logic rd_addr_ok;
   logic data_used;
   logic wr_ctl_one;
   logic wr_ctl_a;
   logic wr_ctl_b;
   logic wr_ctl_c;
   logic wr_status;
   logic wr_addr_a;
   logic wr_addr_b;
   logic wr_addr_c;
   logic wr_data_high;
   logic wr_data_low;
   logic wr_mask_high;
   logic wr_mask_low;
   logic match_gate;
   logic [2:0] qual_match;
   logic [2:0] status_clr;
   logic [2:0] status_kept;

   // Address compare, one instance per comparator
   // address low compare
   dbgc_bit_match #(.WIDTH(8)) u_addr_a (
      .value(bus_addr),
      .compare(st_r.addr_low_a),
      .mask(8'hff),
      .hit(addr_hit[0])
   );

   dbgc_bit_match #(.WIDTH(8)) u_addr_b (
      .value(bus_addr),
      .compare(st_r.addr_low_b),
      .mask(8'hff),
      .hit(addr_hit[1])
   );

   dbgc_bit_match #(.WIDTH(8)) u_addr_c (
      .value(bus_addr),
      .compare(st_r.addr_low_c),
      .mask(8'hff),
      .hit(addr_hit[2])
   );

   // Data compare for comparator A only
   // data high compare
   dbgc_bit_match #(.WIDTH(8)) u_data_hi (
      .value(bus_data[15:8]),
      .compare(st_r.data_high),
      .mask(st_r.mask_high),
      .hit(data_hit_hi)
   );

   dbgc_bit_match #(.WIDTH(8)) u_data_lo (
      .value(bus_data[7:0]),
      .compare(st_r.data_low),
      .mask(st_r.mask_low),
      .hit(data_hit_lo)
   );

   // Bank decode and write permission
   always_comb begin
      bank_is_a = (st_r.bank == dbgc_pkg::BANK_A);
      bank_visible = (st_r.bank != dbgc_pkg::BANK_NONE);
      // address low written only while disarmed
      wr_addr_low = reg_wr && (reg_addr == dbgc_pkg::OFS_COMPARATOR_ADDRESS_LOW) && !st_r.arm && bank_visible;
      // data writes need bank A and disarmed
      wr_data_ok = reg_wr && bank_is_a && !st_r.arm;
   end

   // Read permission
   always_comb begin
      // data registers read in bank A only
      rd_data_ok = bank_is_a;
      // address low readable in any visible bank
      rd_addr_ok = bank_visible;
   end

   // Per-register write enables
   always_comb begin
      // Control and status registers accept writes at any time
      wr_ctl_one = reg_wr && (reg_addr == dbgc_pkg::OFS_DEBUG_CONTROL_ONE);
      wr_ctl_a = reg_wr && (reg_addr == dbgc_pkg::OFS_COMPARATOR_A_CONTROL);
      wr_ctl_b = reg_wr && (reg_addr == dbgc_pkg::OFS_COMPARATOR_B_CONTROL);
      wr_ctl_c = reg_wr && (reg_addr == dbgc_pkg::OFS_COMPARATOR_C_CONTROL);
      wr_status = reg_wr && (reg_addr == dbgc_pkg::OFS_MATCH_STATUS);
      // address write goes to selected bank
      wr_addr_a = wr_addr_low && (st_r.bank == dbgc_pkg::BANK_A);
      wr_addr_b = wr_addr_low && (st_r.bank == dbgc_pkg::BANK_B);
      wr_addr_c = wr_addr_low && (st_r.bank == dbgc_pkg::BANK_C);
      wr_data_high = wr_data_ok && (reg_addr == dbgc_pkg::OFS_COMPARATOR_DATA_HIGH);
      wr_data_low = wr_data_ok && (reg_addr == dbgc_pkg::OFS_COMPARATOR_DATA_LOW);
      wr_mask_high = wr_data_ok && (reg_addr == dbgc_pkg::OFS_COMPARATOR_DATA_HIGH_MASK);
      wr_mask_low = wr_data_ok && (reg_addr == dbgc_pkg::OFS_COMPARATOR_DATA_LOW_MASK);
   end

   // Address low register visible in the window
   always_comb begin
      unique case (st_r.bank)
         dbgc_pkg::BANK_A: addr_low_sel = st_r.addr_low_a;
         dbgc_pkg::BANK_B: addr_low_sel = st_r.addr_low_b;
         dbgc_pkg::BANK_C: addr_low_sel = st_r.addr_low_c;
         dbgc_pkg::BANK_NONE: addr_low_sel = 8'h00;
      endcase
   end

   // Match decision
   always_comb begin
      data_used = !st_r.tag_a;
      data_hit = !data_used || (data_hit_hi && data_hit_lo);
      raw_match[0] = addr_hit[0] && data_hit;
      raw_match[1] = addr_hit[1];
      raw_match[2] = addr_hit[2];
   end

   // Match qualification and status update
   always_comb begin
      match_gate = bus_valid && st_r.arm;
      qual_match = match_gate ? (raw_match & st_r.cmp_en) : dbgc_pkg::RST_MATCH;
      // Sticky status, write one clears, a new match wins
      status_clr = wr_status ? reg_wdata[2:0] : 3'h0;
      status_kept = st_r.sticky & ~status_clr;
   end

   // Read multiplexer
   always_comb begin
      rd_val = 8'h00;
      unique case (reg_addr)
         dbgc_pkg::OFS_DEBUG_CONTROL_ONE: begin
            rd_val[dbgc_pkg::CTL1_ARM_BIT] = st_r.arm;
            rd_val[dbgc_pkg::CTL1_BANK_LSB +: 2] = st_r.bank;
         end
         dbgc_pkg::OFS_COMPARATOR_A_CONTROL: begin
            rd_val[dbgc_pkg::CCTL_TAG_BIT] = st_r.tag_a;
            rd_val[dbgc_pkg::CCTL_ENABLE_BIT] = st_r.cmp_en[0];
         end
         dbgc_pkg::OFS_COMPARATOR_B_CONTROL: begin
            rd_val[dbgc_pkg::CCTL_ENABLE_BIT] = st_r.cmp_en[1];
         end
         dbgc_pkg::OFS_COMPARATOR_C_CONTROL: begin
            rd_val[dbgc_pkg::CCTL_ENABLE_BIT] = st_r.cmp_en[2];
         end
         dbgc_pkg::OFS_MATCH_STATUS: begin
            rd_val[2:0] = st_r.sticky;
         end
         dbgc_pkg::OFS_COMPARATOR_ADDRESS_LOW: begin
            if (rd_addr_ok) begin
               rd_val = addr_low_sel;
            end
         end
         // data registers read in bank A only
         dbgc_pkg::OFS_COMPARATOR_DATA_HIGH: begin
            if (rd_data_ok) begin
               rd_val = st_r.data_high;
            end
         end
         dbgc_pkg::OFS_COMPARATOR_DATA_LOW: begin
            if (rd_data_ok) begin
               rd_val = st_r.data_low;
            end
         end
         dbgc_pkg::OFS_COMPARATOR_DATA_HIGH_MASK: begin
            if (rd_data_ok) begin
               rd_val = st_r.mask_high;
            end
         end
         dbgc_pkg::OFS_COMPARATOR_DATA_LOW_MASK: begin
            if (rd_data_ok) begin
               rd_val = st_r.mask_low;
            end
         end
         default: begin
            rd_val = 8'h00;
         end
      endcase
   end

   // Next state
   always_comb begin
      st_nxt = st_r;

      // Read data stand for the one cycle after the strobe
      st_nxt.rdata = reg_rd ? rd_val : 8'h00;

      // Control registers accept writes at any time
      if (wr_ctl_one) begin
         st_nxt.arm = reg_wdata[dbgc_pkg::CTL1_ARM_BIT];
         st_nxt.bank = reg_wdata[dbgc_pkg::CTL1_BANK_LSB +: 2];
      end

      if (wr_ctl_a) begin
         st_nxt.tag_a = reg_wdata[dbgc_pkg::CCTL_TAG_BIT];
         st_nxt.cmp_en[0] = reg_wdata[dbgc_pkg::CCTL_ENABLE_BIT];
      end

      if (wr_ctl_b) begin
         st_nxt.cmp_en[1] = reg_wdata[dbgc_pkg::CCTL_ENABLE_BIT];
      end

      if (wr_ctl_c) begin
         st_nxt.cmp_en[2] = reg_wdata[dbgc_pkg::CCTL_ENABLE_BIT];
      end

      if (wr_addr_a) begin
         st_nxt.addr_low_a = reg_wdata;
      end

      if (wr_addr_b) begin
         st_nxt.addr_low_b = reg_wdata;
      end

      if (wr_addr_c) begin
         st_nxt.addr_low_c = reg_wdata;
      end

      if (wr_data_high) begin
         st_nxt.data_high = reg_wdata;
      end

      if (wr_data_low) begin
         st_nxt.data_low = reg_wdata;
      end

      if (wr_mask_high) begin
         st_nxt.mask_high = reg_wdata;
      end

      if (wr_mask_low) begin
         st_nxt.mask_low = reg_wdata;
      end

      st_nxt.match = qual_match;

      // Sticky status, a new match wins over the clear
      st_nxt.sticky = status_kept | qual_match;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r.addr_low_a <= dbgc_pkg::RST_REG8;
         st_r.addr_low_b <= dbgc_pkg::RST_REG8;
         st_r.addr_low_c <= dbgc_pkg::RST_REG8;
         st_r.data_high <= dbgc_pkg::RST_REG8;
         st_r.data_low <= dbgc_pkg::RST_REG8;
         st_r.mask_high <= dbgc_pkg::RST_REG8;
         st_r.mask_low <= dbgc_pkg::RST_REG8;
         st_r.arm <= 1'b0;
         st_r.bank <= dbgc_pkg::RST_BANK;
         st_r.tag_a <= 1'b0;
         st_r.cmp_en <= dbgc_pkg::RST_CMP_EN;
         st_r.match <= dbgc_pkg::RST_MATCH;
         st_r.sticky <= dbgc_pkg::RST_MATCH;
         st_r.rdata <= dbgc_pkg::RST_REG8;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign reg_rdata = st_r.rdata;
   assign match = st_r.match;
   assign armed = st_r.arm;

endmodule

/* File: dbgc_props.sv */
// Port checker for the debug comparator register block
module dbgc_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Observed bus and results
   input wire logic bus_valid,
   input wire logic [7:0] bus_addr,
   input wire logic [15:0] bus_data,
   input wire logic [2:0] match,
   input wire logic armed
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire ctl_wr = reg_wr && reg_addr == dbgc_pkg::OFS_DEBUG_CONTROL_ONE;
   wire ctl_rd = reg_rd && reg_addr == dbgc_pkg::OFS_DEBUG_CONTROL_ONE;
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   unmapped_read_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   match_valid_a: assert property (match != 3'h0 |-> $past(bus_valid))
      else $error("match without bus cycle");
   match_arm_a: assert property (match != 3'h0 |-> $past(armed))
      else $error("match while not armed");
   arm_write_a: assert property (ctl_wr |=> armed == $past(reg_wdata[7]))
      else $error("arm bit not taken");
   arm_hold_a: assert property (!ctl_wr |=> $stable(armed))
      else $error("arm changed without write");
   arm_read_a: assert property (ctl_rd |=> reg_rdata[7] == armed)
      else $error("arm readback wrong");
   idle_match_a: assert property ((!armed) [*2] |-> match == 3'h0)
      else $error("match in disarmed run");
   cover property (match[0]);
   cover property (match[1]);
   cover property (match[2]);
   cover property (reg_rd && reg_addr == dbgc_pkg::OFS_COMPARATOR_DATA_HIGH ##1 reg_rdata != 8'h00);
endmodule

bind dbgc_comparator_regs dbgc_props u_props (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_valid(bus_valid),
   .bus_addr(bus_addr), .bus_data(bus_data), .match(match), .armed(armed));

/* File: dbgc_core_model.sv */
// Core bus model driving observed bus cycles
module dbgc_core_model (
   // Clock
   input wire logic clk_sys,
   // Request from the bench
   input wire logic req,
   input wire logic [7:0] req_addr,
   input wire logic [15:0] req_data,
   // Core bus
   output logic bus_valid,
   output logic [7:0] bus_addr,
   output logic [15:0] bus_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] last_r = 24'h000000;
   always @(posedge clk_sys) if (req) last_r <= {req_addr, req_data};
   // Idle cycles show the inverse of the last cycle
   assign bus_valid = req;
   assign bus_addr = req ? req_addr : ~last_r[23:16];
   assign bus_data = req ? req_data : ~last_r[15:0];
endmodule

/* File: dbgc_comparator_regs_tb_top.sv */
// Testbench for the debug comparator register block
module dbgc_comparator_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req = 1'b0, bus_valid, armed;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, req_addr = 8'h00, reg_rdata, bus_addr, v;
   logic [15:0] req_data = 16'h0000, bus_data;
   logic [2:0] match;
   int error_cnt = 0;
   int comparisons = 0;
   always #25 clk_sys = ~clk_sys;
   dbgc_comparator_regs DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_valid(bus_valid), .bus_addr(bus_addr),
      .bus_data(bus_data), .match(match), .armed(armed));
   dbgc_core_model u_core (.clk_sys(clk_sys), .req(req), .req_addr(req_addr), .req_data(req_data),
      .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data));
   task results;
      if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   task busc(input logic [7:0] a, input logic [15:0] d, input logic [2:0] exp);
      @(posedge clk_sys);
      req <= 1'b1;
      req_addr <= a;
      req_data <= d;
      @(posedge clk_sys);
      req <= 1'b0;
      #1 chk({5'h00, match}, {5'h00, exp});
   endtask
   task t_reset;
      for (int i = 0; i < 4; i++) rdc(8'(8'h2b + i), 8'h00);
      rdc(8'h10, 8'h00);
   endtask
   task t_regs;
      wr(8'h2b, 8'ha5);
      wr(8'h2c, 8'h3c);
      wr(8'h2d, 8'hc3);
      wr(8'h2e, 8'hf0);
      wr(8'h2f, 8'hff);
      rdc(8'h2b, 8'ha5);
      rdc(8'h2c, 8'h3c);
      rdc(8'h2d, 8'hc3);
      rdc(8'h2e, 8'hf0);
   endtask
   task t_bank;
      wr(8'h20, 8'h01);
      rdc(8'h2c, 8'h00);
      wr(8'h2c, 8'h11);
      wr(8'h2b, 8'h5a);
      wr(8'h20, 8'h02);
      wr(8'h2b, 8'h77);
      wr(8'h20, 8'h03);
      rdc(8'h2b, 8'h00);
      wr(8'h20, 8'h00);
      rdc(8'h2c, 8'h3c);
      rdc(8'h2b, 8'ha5);
   endtask
   task t_armed;
      wr(8'h21, 8'h01);
      wr(8'h22, 8'h01);
      wr(8'h23, 8'h01);
      wr(8'h20, 8'h80);
      wr(8'h2b, 8'h00);
      wr(8'h2e, 8'h00);
      rdc(8'h2b, 8'ha5);
      rdc(8'h2e, 8'hf0);
      rd(dbgc_pkg::OFS_DEBUG_CONTROL_ONE, v);
      chk(v & 8'h83, 8'h80);
      chk({7'h00, armed}, 8'h01);
   endtask
   task t_match;
      busc(8'ha5, 16'h3cc3, 3'h1);
      busc(8'ha5, 16'h3fc3, 3'h1);
      busc(8'ha5, 16'h7cc3, 3'h0);
      busc(8'ha5, 16'h3cc2, 3'h0);
      busc(8'ha4, 16'h3cc3, 3'h0);
      busc(8'h25, 16'h3cc3, 3'h0);
      busc(8'h5a, 16'h0000, 3'h2);
      busc(8'h77, 16'hffff, 3'h4);
      rdc(dbgc_pkg::OFS_MATCH_STATUS, 8'h07);
      wr(dbgc_pkg::OFS_MATCH_STATUS, 8'h07);
      rdc(dbgc_pkg::OFS_MATCH_STATUS, 8'h00);
   endtask
   task t_tag;
      wr(8'h20, 8'h00);
      wr(8'h21, 8'h21);
      wr(8'h20, 8'h80);
      busc(8'ha5, 16'h0000, 3'h1);
      wr(8'h22, 8'h00);
      busc(8'h5a, 16'h0000, 3'h0);
      wr(8'h20, 8'h00);
      busc(8'ha5, 16'h3cc3, 3'h0);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_bank();
      t_armed();
      t_match();
      t_tag();
      results();
   end
endmodule
